// [core/ures_params.svh]
// Offsets, field positions, reset values and timing counts of the receive status block.
// Assumes a Wishbone byte address whose low two bits are zero.
`ifndef URES_PARAMS_SVH
`define URES_PARAMS_SVH

`define URES_ADR_STATUS     8'h00
`define URES_ADR_MODE       8'h04
`define URES_ADR_RXDATA     8'h08
`define URES_ADR_CONTROL    8'h0c
`define URES_ADR_IRQ_STATUS 8'h10
`define URES_ADR_IRQ_MASK   8'h14
`define URES_ADR_LEVEL      8'h18

`define URES_STATUS_RESET   16'h0060
`define URES_FLAG_MASK      8'hf3
`define URES_PE_CNT_LSB     12
`define URES_FE_CNT_LSB     8
`define URES_BIT_RX_FAULT   7
`define URES_BIT_HEAD_FE    3
`define URES_BIT_HEAD_PE    2

`define URES_MODE_RX_ON     0
`define URES_MODE_PAR_ON    1
`define URES_MODE_PAR_ODD   2
`define URES_MODE_TWO_STOP  3
`define URES_MODE_RESET     4'h0

`define URES_CTRL_FIFO_RST  0
`define URES_IRQ_FAULT      0
`define URES_IRQ_CHAR       1
`define URES_IRQ_OVERRUN    2

`define URES_TICK_DIV       68
`define URES_TICKS_PER_BIT  16
`define URES_START_CHECK    7

`endif

// [core/ures_pkg.sv]
// Types shared by the receive status block.
// Assumes nothing of its surroundings.
package ures_pkg;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP1,
    RX_STOP2
  } ures_rx_state_type;

endpackage : ures_pkg

// [core/ures_fault_counter.sv]
// Count of errored entries held in the receive FIFO.
// Assumes inc and dec are single-cycle pulses on clock.
`timescale 1ns/100ps

module ures_fault_counter #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             inc,
  input  wire logic             dec,
  output      logic [WIDTH-1:0] count
);

  logic [WIDTH-1:0] countQ;

  // Wraps modulo 2**WIDTH, so a full FIFO of errors reads zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      countQ <= '0;
    end else if (clear) begin
      countQ <= '0;
    end else if (inc && !dec) begin
      countQ <= countQ + WIDTH'(1);
    end else if (dec && !inc) begin
      countQ <= countQ - WIDTH'(1);
    end
  end

  assign count = countQ;

  property p_count_wrap;
    @(posedge clock) disable iff (!rst_n)
    (!clear && inc && !dec && countQ == '1) |=> (countQ == '0);
  endproperty
  a_count_wrap: assert property (p_count_wrap) else $error("fault count did not wrap to zero");

  property p_count_clear;
    @(posedge clock) disable iff (!rst_n)
    clear |=> (countQ == '0);
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("fault count not cleared");

endmodule : ures_fault_counter

// [core/ures_status.sv]
// Receive path, 16-entry receive FIFO, status flags and error counts of a serial port.
// Assumes a classic Wishbone master on clock; rxPin is asynchronous; flag set inputs are same-clock pulses.
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`include "ures_params.svh"

// Behaviour
// - Status register is 16 bits: error counts high byte, state flags low byte.
// - Writing 1 to any status flag never sets it.
// - A flag clears on writing 0 only after software read it as 1.
// - Head-entry framing and parity bits are read-only.
// - Reset loads the status register with 0060 hex.
// - Bits 15..12 count FIFO entries received with parity error.
// - Parity count reads zero when all sixteen entries are errored.
// - Bits 11..8 count FIFO entries received with framing error.
// - Framing count reads zero when all sixteen entries are errored.
// - A low first stop bit sets the receive-fault flag.
// - Parity mismatch with parity enabled sets the receive-fault flag.
// - Turning the receiver off leaves the receive-fault flag unchanged.
// - Errored characters still enter the FIFO and reception continues.
// - With two stop bits only the first is checked.
// - Disabling the receiver preserves all receive-side flags.
module ures_status #(
  parameter int DEPTH    = 16,
  parameter int TICK_DIV = `URES_TICK_DIV
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output      logic [31:0] dat_o,
  output      logic        ack_o,
  input  wire logic        rxPin,
  input  wire logic        txDoneSet,
  input  wire logic        txFifoLowSet,
  input  wire logic        lineBreakSet,
  input  wire logic        rxFifoFullSet,
  input  wire logic        rxDataIdleSet,
  output      logic        irq
);

  import ures_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam int LVL_W = PTR_W + 1;
  localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);

  ures_rx_state_type rxState_q;
  logic [1:0]        rxSync_q;
  logic [15:0]       tickCnt_q;
  logic              tick;
  logic [3:0]        subCnt_q;
  logic [2:0]        bitIdx_q;
  logic [7:0]        shift_q;
  logic              parBit_q;
  logic [3:0]        mode_q;
  logic              rxBit;
  logic              sampleNow;
  logic              charDone;
  logic              frameErr;
  logic              parityErr;
  logic [9:0]        mem [DEPTH];
  logic [PTR_W-1:0]  wrPtr_q;
  logic [PTR_W-1:0]  rdPtr_q;
  logic [LVL_W-1:0]  level_q;
  logic              push;
  logic              pop;
  logic              fifoReset;
  logic              headFe;
  logic              headPe;
  logic [3:0]        peCount;
  logic [3:0]        feCount;
  logic [7:0]        flag_q;
  logic [7:0]        arm_q;
  logic [7:0]        flagSet;
  logic [15:0]       statusValue;
  logic              ack_q;
  logic [31:0]       dat_q;
  logic              accept;
  logic              wrStatus;
  logic              rdStatus;
  logic [2:0]        irqStatus_q;
  logic [2:0]        irqMask_q;
  logic [2:0]        irqEvent;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and bit-rate divider

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rxSync_q <= 2'h3;
    end else begin
      rxSync_q <= {rxSync_q[0], rxPin};
    end
  end

  assign rxBit = rxSync_q[1];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_q <= 16'h0000;
    end else if (tickCnt_q == 16'(TICK_DIV - 1)) begin
      tickCnt_q <= 16'h0000;
    end else begin
      tickCnt_q <= tickCnt_q + 16'h0001;
    end
  end

  assign tick      = (tickCnt_q == 16'(TICK_DIV - 1));
  assign sampleNow = tick && (subCnt_q == 4'(`URES_TICKS_PER_BIT - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Receiver

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rxState_q <= RX_IDLE;
    end else if (!mode_q[`URES_MODE_RX_ON]) begin
      rxState_q <= RX_IDLE;
    end else begin
      case (rxState_q)
        RX_IDLE: begin
          if (!rxBit) rxState_q <= RX_START;
        end
        RX_START: begin
          if (tick && subCnt_q == 4'(`URES_START_CHECK)) rxState_q <= rxBit ? RX_IDLE : RX_DATA;
        end
        RX_DATA: begin
          if (sampleNow && bitIdx_q == 3'h7) begin
            rxState_q <= mode_q[`URES_MODE_PAR_ON] ? RX_PARITY : RX_STOP1;
          end
        end
        RX_PARITY: begin
          if (sampleNow) rxState_q <= RX_STOP1;
        end
        RX_STOP1: begin
          if (sampleNow) rxState_q <= mode_q[`URES_MODE_TWO_STOP] ? RX_STOP2 : RX_IDLE;
        end
        RX_STOP2: begin
          if (sampleNow) rxState_q <= RX_IDLE;
        end
        default: rxState_q <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      subCnt_q <= 4'h0;
    end else if (rxState_q == RX_IDLE) begin
      subCnt_q <= 4'h0;
    end else if (tick) begin
      if (rxState_q == RX_START && subCnt_q == 4'(`URES_START_CHECK)) begin
        subCnt_q <= 4'h0;
      end else begin
        subCnt_q <= subCnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bitIdx_q <= 3'h0;
      shift_q  <= 8'h00;
    end else if (rxState_q == RX_START) begin
      bitIdx_q <= 3'h0;
    end else if (rxState_q == RX_DATA && sampleNow) begin
      bitIdx_q <= bitIdx_q + 3'h1;
      shift_q  <= {rxBit, shift_q[7:1]};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      parBit_q <= 1'b0;
    end else if (rxState_q == RX_PARITY && sampleNow) begin
      parBit_q <= rxBit;
    end
  end

  assign charDone  = (rxState_q == RX_STOP1) && sampleNow && mode_q[`URES_MODE_RX_ON];
  assign frameErr  = !rxBit;
  assign parityErr = mode_q[`URES_MODE_PAR_ON] && ((^{shift_q, parBit_q}) != mode_q[`URES_MODE_PAR_ODD]);

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO with per-entry error bits

  assign push = charDone && (level_q != FULL_LVL) && !fifoReset;
  assign pop  = accept && !we_i && adr_i == `URES_ADR_RXDATA && level_q != '0 && !fifoReset;

  always_ff @(posedge clock) begin
    if (push) mem[wrPtr_q] <= {parityErr, frameErr, shift_q};
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      level_q <= '0;
    end else if (fifoReset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      level_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + PTR_W'(1);
      if (pop) rdPtr_q <= rdPtr_q + PTR_W'(1);
      if (push && !pop) level_q <= level_q + LVL_W'(1);
      if (pop && !push) level_q <= level_q - LVL_W'(1);
    end
  end

  assign headFe = (level_q != '0) && mem[rdPtr_q][8];
  assign headPe = (level_q != '0) && mem[rdPtr_q][9];

  ures_fault_counter #(.WIDTH(4)) uParityCount (
    .clock (clock),
    .rst_n (rst_n),
    .clear (fifoReset),
    .inc   (push && parityErr),
    .dec   (pop && headPe),
    .count (peCount)
  );

  ures_fault_counter #(.WIDTH(4)) uFrameCount (
    .clock (clock),
    .rst_n (rst_n),
    .clear (fifoReset),
    .inc   (push && frameErr),
    .dec   (pop && headFe),
    .count (feCount)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status flags with read-then-write-0 clearing

  assign flagSet = {charDone && (frameErr || parityErr), txDoneSet, txFifoLowSet, lineBreakSet,
                    2'b00, rxFifoFullSet, rxDataIdleSet};

  for (genvar i = 0; i < 8; i++) begin : gFlag
    if ((8'(1 << i) & `URES_FLAG_MASK) != 8'h00) begin : gRw
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          flag_q[i] <= 1'(`URES_STATUS_RESET >> i);
        end else if (flagSet[i]) begin
          flag_q[i] <= 1'b1;
        end else if (wrStatus && !dat_i[i] && arm_q[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          arm_q[i] <= 1'b0;
        end else if (flagSet[i] || !flag_q[i]) begin
          arm_q[i] <= 1'b0;
        end else if (wrStatus && !dat_i[i]) begin
          arm_q[i] <= 1'b0;
        end else if (rdStatus) begin
          arm_q[i] <= 1'b1;
        end
      end
    end else begin : gRo
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          flag_q[i] <= 1'b0;
          arm_q[i]  <= 1'b0;
        end else begin
          flag_q[i] <= 1'b0;
          arm_q[i]  <= 1'b0;
        end
      end
    end
  end

  assign statusValue = {peCount, feCount, flag_q[7:4], headFe, headPe, flag_q[1:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  assign accept    = cyc_i && stb_i && !ack_q;
  assign wrStatus  = accept && we_i && sel_i[0] && adr_i == `URES_ADR_STATUS;
  assign rdStatus  = accept && !we_i && adr_i == `URES_ADR_STATUS;
  assign fifoReset = accept && we_i && sel_i[0] && adr_i == `URES_ADR_CONTROL && dat_i[`URES_CTRL_FIFO_RST];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= accept;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dat_q <= 32'h00000000;
    end else if (accept && !we_i) begin
      if (adr_i == `URES_ADR_STATUS) begin
        dat_q <= {16'h0000, statusValue};
      end else if (adr_i == `URES_ADR_MODE) begin
        dat_q <= {28'h0000000, mode_q};
      end else if (adr_i == `URES_ADR_RXDATA) begin
        dat_q <= {24'h000000, (level_q != '0) ? mem[rdPtr_q][7:0] : 8'h00};
      end else if (adr_i == `URES_ADR_IRQ_STATUS) begin
        dat_q <= {29'h00000000, irqStatus_q};
      end else if (adr_i == `URES_ADR_IRQ_MASK) begin
        dat_q <= {29'h00000000, irqMask_q};
      end else if (adr_i == `URES_ADR_LEVEL) begin
        dat_q <= {{(32 - LVL_W){1'b0}}, level_q};
      end else begin
        dat_q <= 32'h00000000;
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `URES_MODE_RESET;
    end else if (accept && we_i && sel_i[0] && adr_i == `URES_ADR_MODE) begin
      mode_q <= dat_i[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  assign irqEvent = {charDone && !push, push, flagSet[`URES_BIT_RX_FAULT]};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus_q <= 3'h0;
    end else if (accept && we_i && sel_i[0] && adr_i == `URES_ADR_IRQ_STATUS) begin
      irqStatus_q <= (irqStatus_q & ~dat_i[2:0]) | irqEvent;
    end else begin
      irqStatus_q <= irqStatus_q | irqEvent;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irqMask_q <= 3'h0;
    end else if (accept && we_i && sel_i[0] && adr_i == `URES_ADR_IRQ_MASK) begin
      irqMask_q <= dat_i[2:0];
    end
  end

  assign irq = |(irqStatus_q & irqMask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_no_set_by_write;
    (wrStatus && dat_i[7] && !flag_q[7] && !flagSet[7]) |=> !flag_q[7];
  endproperty
  a_no_set_by_write: assert property (p_no_set_by_write) else $error("write of 1 set a flag");

  property p_clear_needs_read;
    (wrStatus && !dat_i[6] && flag_q[6] && !arm_q[6] && !flagSet[6]) |=> flag_q[6];
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read) else $error("flag cleared without read");

  property p_clear_after_read;
    (rdStatus && flag_q[7] && !flagSet[7]) ##1 (!flagSet[7])[*2] ##1
    (wrStatus && !dat_i[7] && !flagSet[7]) |=> !flag_q[7];
  endproperty
  a_clear_after_read: assert property (p_clear_after_read) else $error("read then write 0 did not clear");

  property p_head_read_only;
    (wrStatus && dat_i[3:2] == 2'b11 && level_q == '0 && !push) |=> (statusValue[3:2] == 2'b00);
  endproperty
  a_head_read_only: assert property (p_head_read_only) else $error("head error bits written");

  property p_pe_count_inc;
    (push && parityErr && !pop) |=> (peCount == $past(peCount) + 4'h1);
  endproperty
  a_pe_count_inc: assert property (p_pe_count_inc) else $error("parity count did not follow push");

  property p_fe_count_dec;
    (pop && headFe && !(push && frameErr)) |=> (feCount == $past(feCount) - 4'h1);
  endproperty
  a_fe_count_dec: assert property (p_fe_count_dec) else $error("framing count did not follow pop");

  property p_full_fe_zero;
    (level_q == FULL_LVL && feCount == 4'h0 && $past(level_q) != FULL_LVL && $past(feCount) == 4'hf)
    |-> headFe;
  endproperty
  a_full_fe_zero: assert property (p_full_fe_zero) else $error("framing count wrap inconsistent");

  property p_stop_low_sets_fault;
    (charDone && !rxBit) |=> flag_q[7];
  endproperty
  a_stop_low_sets_fault: assert property (p_stop_low_sets_fault) else $error("bad stop bit missed");

  property p_parity_sets_fault;
    (charDone && parityErr) |=> (flag_q[7] && irqStatus_q[`URES_IRQ_FAULT]);
  endproperty
  a_parity_sets_fault: assert property (p_parity_sets_fault) else $error("parity error missed");

  property p_rx_off_keeps_flag;
    ($fell(mode_q[`URES_MODE_RX_ON]) && !wrStatus) |-> $stable(flag_q[7]);
  endproperty
  a_rx_off_keeps_flag: assert property (p_rx_off_keeps_flag) else $error("receiver off changed fault flag");

  property p_errored_stored;
    (charDone && frameErr && level_q != FULL_LVL && !fifoReset) |=> (headFe || level_q > LVL_W'(1));
  endproperty
  a_errored_stored: assert property (p_errored_stored) else $error("errored character not stored");

  property p_second_stop_ignored;
    (rxState_q == RX_STOP2) |-> !charDone;
  endproperty
  a_second_stop_ignored: assert property (p_second_stop_ignored) else $error("second stop bit checked");

  c_frame_error:  cover property (push && frameErr);
  c_parity_error: cover property (push && parityErr);
  c_fault_clear:  cover property (flag_q[7] ##1 !flag_q[7]);
  c_count_wrap:   cover property (level_q == FULL_LVL && peCount == 4'h0 && headPe);

endmodule : ures_status

// [tb/ures_serial_peer.sv]
// Behavioural serial transmitter that drives the receive line.
// Assumes the receiver oversamples each bit 16 times, at one tick every TICK_DIV clocks.
`timescale 1ns/100ps

module ures_serial_peer #(
  parameter int TICK_DIV = 2
) (
  input  wire logic clock,
  output      logic rxPin
);
  localparam int BitClk = 16 * TICK_DIV;

  initial rxPin = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Line level held for a number of clocks
  task automatic hold(input logic v, input int clks);
    @(posedge clock);
    rxPin <= v;
    repeat (clks - 1) @(posedge clock);
  endtask : hold

  // Bad stop is low past mid-bit only, so no phantom start follows
  task automatic stopBit(input logic v);
    if (v) begin
      hold(1'b1, BitClk);
    end else begin
      hold(1'b0, 12 * TICK_DIV);
      hold(1'b1, 4 * TICK_DIV);
    end
  endtask : stopBit

  ////////////////////////////////////////////////////////////////////////////////
  // One frame, LSB first, then two idle bit times
  task automatic send(input logic [7:0] d, input logic parOn, input logic parOdd, input logic parBad,
                      input logic stop1, input logic stop2, input logic twoStop);
    logic p;
    p = (^d) ^ parOdd ^ parBad;
    hold(1'b0, BitClk);
    for (int i = 0; i < 8; i++) begin
      hold(d[i], BitClk);
    end
    if (parOn) begin
      hold(p, BitClk);
    end
    stopBit(stop1);
    if (twoStop) begin
      stopBit(stop2);
    end
    hold(1'b1, 2 * BitClk);
  endtask : send
endmodule : ures_serial_peer

// [tb/tb_top.sv]
// Self-checking bench of the receive status block.
// Assumes the serial peer model and a classic Wishbone master written here.
`timescale 1ns/100ps
`include "ures_params.svh"

module tb_top;
  import ures_pkg::*;
  localparam int TickDiv = 2;
  logic        clock;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datW;
  logic [31:0] datR;
  logic        ack;
  logic        rxPin;
  logic        irq;
  logic [4:0]  sets;
  logic [31:0] q;
  int          errorCnt;
  int          cmpCount;

  ures_status #(.DEPTH(16), .TICK_DIV(TickDiv)) DUT (
    .clock(clock), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(datW), .dat_o(datR), .ack_o(ack), .rxPin(rxPin), .txDoneSet(sets[4]), .txFifoLowSet(sets[3]),
    .lineBreakSet(sets[2]), .rxFifoFullSet(sets[1]), .rxDataIdleSet(sets[0]), .irq(irq)
  );

  ures_serial_peer #(.TICK_DIV(TickDiv)) peer (.clock(clock), .rxPin(rxPin));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus cycles, verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmpCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1, "no bus answer");
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    wb(a, 1'b0, 32'h0);
    chk(q, exp, msg);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1'b1, d);
  endtask : wr

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic testFlags;
    chk(datR, 32'h0, "read data after reset");
    wr(`URES_ADR_STATUS, 32'h0000);
    rd(`URES_ADR_STATUS, 32'h0060, "status reset, clear before read");
    wr(`URES_ADR_STATUS, 32'h00ff);
    rd(`URES_ADR_STATUS, 32'h0060, "write ones");
    wr(`URES_ADR_STATUS, 32'h0000);
    rd(`URES_ADR_STATUS, 32'h0000, "clear after read");
    @(posedge clock) sets <= 5'h1f;
    @(posedge clock) sets <= 5'h00;
    rd(`URES_ADR_STATUS, 32'h0073, "flags set");
    wr(`URES_ADR_STATUS, 32'h0000);
    rd(`URES_ADR_STATUS, 32'h0000, "all flags cleared");
    $display("test flags done");
  endtask : testFlags

  task automatic testFraming;
    wr(`URES_ADR_MODE, 32'h1);
    peer.send(8'ha5, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    rd(`URES_ADR_STATUS, 32'h0188, "framing status");
    rd(`URES_ADR_LEVEL, 32'h1, "errored entry stored");
    rd(`URES_ADR_RXDATA, 32'ha5, "errored data");
    rd(`URES_ADR_STATUS, 32'h0080, "count after pop");
    peer.send(8'h3c, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    wr(`URES_ADR_STATUS, 32'h0000);
    rd(`URES_ADR_STATUS, 32'h0000, "fault cleared");
    rd(`URES_ADR_RXDATA, 32'h3c, "reception continues");
    $display("test framing done");
  endtask : testFraming

  task automatic testParity;
    wr(`URES_ADR_MODE, 32'h3);
    peer.send(8'h07, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    rd(`URES_ADR_STATUS, 32'h1084, "even parity error");
    wr(`URES_ADR_MODE, 32'h7);
    peer.send(8'h07, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    rd(`URES_ADR_STATUS, 32'h1084, "odd parity good");
    rd(`URES_ADR_RXDATA, 32'h07, "first entry");
    rd(`URES_ADR_STATUS, 32'h0080, "parity count after pop");
    rd(`URES_ADR_RXDATA, 32'h07, "second entry");
    wr(`URES_ADR_STATUS, 32'h0000);
    $display("test parity done");
  endtask : testParity

  task automatic testTwoStop;
    wr(`URES_ADR_MODE, 32'h9);
    peer.send(8'h55, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    rd(`URES_ADR_STATUS, 32'h0000, "second stop ignored");
    rd(`URES_ADR_RXDATA, 32'h55, "two stop data");
    $display("test two stop done");
  endtask : testTwoStop

  task automatic testWrap;
    wr(`URES_ADR_MODE, 32'h3);
    for (int i = 0; i < 16; i++) begin
      peer.send(i[7:0], 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    end
    rd(`URES_ADR_STATUS, 32'h008c, "counts wrap");
    rd(`URES_ADR_LEVEL, 32'h10, "fifo full");
    peer.send(8'h77, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    rd(`URES_ADR_STATUS, 32'h008c, "overrun keeps counts");
    rd(`URES_ADR_IRQ_STATUS, 32'h7, "irq events");
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(`URES_ADR_IRQ_MASK, 32'h4);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(`URES_ADR_IRQ_STATUS, 32'h7);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rd(`URES_ADR_RXDATA, 32'h00, "head popped");
    rd(`URES_ADR_STATUS, 32'hff8c, "counts fifteen");
    wr(`URES_ADR_CONTROL, 32'h1);
    wb(`URES_ADR_STATUS, 1'b0, 32'h0);
    chk(q & 32'hff00, 32'h0, "counts after fifo reset");
    $display("test wrap done");
  endtask : testWrap

  task automatic testRxOff;
    wr(`URES_ADR_MODE, 32'h0);
    wb(`URES_ADR_STATUS, 1'b0, 32'h0);
    chk(q & 32'h80, 32'h80, "fault kept when off");
    peer.send(8'h11, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    rd(`URES_ADR_LEVEL, 32'h0, "line ignored when off");
    wb(`URES_ADR_STATUS, 1'b0, 32'h0);
    chk(q & 32'h80, 32'h80, "fault still kept");
    $display("test receiver off done");
  endtask : testRxOff

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog and main sequence
  initial begin
    repeat (60000) @(posedge clock);
    errorCnt++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    datW = 32'h0;
    sets = 5'h00;
    errorCnt = 0;
    cmpCount = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    testFlags();
    testFraming();
    testParity();
    testTwoStop();
    testWrap();
    testRxOff();
    conclude();
  end
endmodule : tb_top
